/* File: logic/flash_lock_defines.svh */
// Constants shared by the flash lock-and-key device and its processor-side end
`ifndef FLASH_LOCK_DEFINES_SVH
`define FLASH_LOCK_DEFINES_SVH
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define ERASED_BYTE 8'hFF
`define FLASH_ADDR_W 14
`define FLASH_WORDS 16384
`define PROG_TIME_NS 40000
`define ERASE_TIME_NS 200000
`define CLK_PERIOD_NS 10
`define WB_CTRL 4'h0
`define WB_STAT 4'h4
`define WB_IRQ 4'h8
`define WB_MASK 4'hC
`define EV_DONE 0
`define EV_VIOL 1
`define EV_FERR 2
`endif

/* File: logic/flash_lock_pkg.sv */
// Types shared by both ends of the flash lock link
package flash_lock_pkg;
  // Key checker states, one-hot
  typedef enum logic [3:0] {
    KS_LOCKED = 4'b0001,
    KS_FIRST = 4'b0010,
    KS_OPEN = 4'b0100,
    KS_DISABLED = 4'b1000
  } key_state_e;
  // Operation kinds on the link
  typedef enum logic [1:0] {
    OP_KEY = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_SEL = 2'b11
  } op_e;
endpackage

/* File: logic/flash_lock_if.sv */
// Link between processor end and flash lock device
`timescale 1ns/1ns
interface flash_lock_if;
  logic req;                 // Request strobe, one cycle
  flash_lock_pkg::op_e op;   // Kind of request
  logic [13:0] addr;         // Flash byte address
  logic [7:0] data;          // Key, data or select value
  logic stall;               // Processor must wait
  logic done;                // Request finished, one cycle
  logic flash_err_rst;       // Flash error reset pulse
  logic supply_on;           // Supply monitor enabled
  logic supply_rst_en;       // Supply monitor is a reset source
  logic select;              // Write-select bit state
  logic [3:0] key_state;     // Key checker state
  modport device (input req, op, addr, data, supply_on, supply_rst_en,
                  output stall, done, flash_err_rst, select, key_state);
  modport core (output req, op, addr, data, supply_on, supply_rst_en,
                input stall, done, flash_err_rst, select, key_state);
endinterface

/* File: logic/flash_lock_device.sv */
// Flash lock-and-key device: key checker, write-select bit and timed flash array
//
// What this block does
// - Programming only clears bits, never sets
// - Erase sets whole page to all ones
// - Program and erase timed internally
// - Stall execution while operation runs
// - Select bit routes writes to flash
// - Select bit stays until software or a flash error reset clears it
// - Processor sets select, then writes keys
// - Unarmed supply monitor causes error reset
// - Software arms monitor then reset source
// - Unlock needs 0xA5 then 0xF1
// - No time limit between key writes
// - Bad key disables flash until reset
// - Early flash write disables until reset
// - Relock after every completed operation
// - Processor programs via data move write
`timescale 1ns/1ns
`include "flash_lock_defines.svh"
module flash_lock_device #(
  parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS,
  parameter int ERASE_CYCLES = `ERASE_TIME_NS / `CLK_PERIOD_NS,
  parameter int PAGE_W = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to processor
  flash_lock_if.device lnk,
  // Read port of the flash array
  input wire logic [`FLASH_ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Status
  output logic disabled_o,
  output logic busy_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  // All device state in one register; the array sits beside it
  typedef struct packed {
    flash_lock_pkg::key_state_e ks;  // Key checker
    logic sel;                       // Write-select bit
    logic busy;                      // Operation in progress
    logic erase;                     // Running operation is an erase
    logic [17:0] cnt;                // Remaining cycles
    logic [`FLASH_ADDR_W-1:0] addr;  // Target byte
    logic [7:0] data;                // Byte to program
    logic done;                      // Finish pulse
    logic ferr;                      // Error reset pulse
    logic [7:0] rdat;                // Registered read data
  } state_s;
  state_s st, next_st;

  // ----------------------------------------
  // Flash array and supply monitor
  // ----------------------------------------
  // Flash array; kept outside the struct as a memory
  // Not reset: a byte is only known once its page has been erased
  logic [7:0] mem [0:`FLASH_WORDS-1];
  logic wr_prog, wr_erase;           // Array update strobes
  logic [`FLASH_ADDR_W-1:0] page_base;  // First byte of the page to erase
  logic armed;                       // Supply monitor fully armed

  // Both bits are needed; a monitor that cannot reset does not guard the array
  assign armed = lnk.supply_on & lnk.supply_rst_en;
  // Erase acts on a whole page, so the low address bits are dropped
  assign page_base = {st.addr[`FLASH_ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Requests are only taken while idle; the core waits for done before the next
  always_comb begin
    logic flash_op;
    flash_op = 1'b0;
    next_st = st;
    // Pulses last one cycle unless set again below
    next_st.done = 1'b0;
    next_st.ferr = 1'b0;
    // Array strobes are one-cycle pulses from the commit cycle
    wr_prog = 1'b0;
    wr_erase = 1'b0;
    // Read port: one cycle of latency
    next_st.rdat = mem[rd_addr_i];
    if (st.busy) begin
      // Hardware timing; no polling needed
      if (st.cnt == 18'd1) begin
        // Last cycle: commit the array write and relock
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        wr_prog = ~st.erase;
        wr_erase = st.erase;
        next_st.ks = flash_lock_pkg::KS_LOCKED;
      end else begin
        // Count down the operation time
        next_st.cnt = st.cnt - 18'd1;
      end
    // Idle: take a new request
    end else if (lnk.req) begin
      case (lnk.op)
        flash_lock_pkg::OP_SEL: begin
          // Only software sets the select bit; a flash error reset also clears it
          next_st.sel = lnk.data[0];
          next_st.done = 1'b1;
        end
        flash_lock_pkg::OP_KEY: begin
          // A key write always finishes, even when refused
          next_st.done = 1'b1;
          // Order and value decide, no timeout
          case (st.ks)
            flash_lock_pkg::KS_LOCKED: begin
              // Only the first code is accepted here
              next_st.ks = (lnk.data == `KEY_FIRST) ? flash_lock_pkg::KS_FIRST
                                                     : flash_lock_pkg::KS_DISABLED;
            end
            flash_lock_pkg::KS_FIRST: begin
              // Only the second code unlocks
              next_st.ks = (lnk.data == `KEY_SECOND) ? flash_lock_pkg::KS_OPEN
                                                      : flash_lock_pkg::KS_DISABLED;
            end
            flash_lock_pkg::KS_OPEN: begin
              // A third key is out of order
              next_st.ks = flash_lock_pkg::KS_DISABLED;
            end
            default: begin
              next_st.ks = flash_lock_pkg::KS_DISABLED;
            end
          endcase
        end
        default: begin
          // Program or erase: checked below
          flash_op = 1'b1;
        end
      endcase
      // Checks run in order: select, supply monitor, then the lock
      if (flash_op) begin
        next_st.done = 1'b1;
        if (!st.sel) begin
          // Without select the write goes elsewhere; ignored here
          next_st.done = 1'b1;
        end else if (!armed) begin
          // Error reset takes priority over the lock state
          next_st.ferr = 1'b1;
          next_st.ks = flash_lock_pkg::KS_LOCKED;
        end else if (st.ks == flash_lock_pkg::KS_OPEN) begin
          // Route the data move write to flash
          next_st.done = 1'b0;
          next_st.busy = 1'b1;
          next_st.erase = (lnk.op == flash_lock_pkg::OP_ERASE);
          next_st.cnt = (lnk.op == flash_lock_pkg::OP_ERASE) ?
                        18'(ERASE_CYCLES) : 18'(PROG_CYCLES);
          next_st.addr = lnk.addr;
          next_st.data = lnk.data;
        end else begin
          // Attempt before the keys: locked out until reset
          next_st.ks = flash_lock_pkg::KS_DISABLED;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Flash-error reset lands one cycle after its pulse, like a system reset
  always_ff @(posedge clk_i) begin
    if (rst_i || st.ferr) begin
      // Error reset acts like a system reset on this block
      st <= '0;
      st.ks <= flash_lock_pkg::KS_LOCKED;
    end else begin
      // Normal update
      st <= next_st;
    end
  end

  // Array writes: program ANDs, erase fills a page with ones
  always_ff @(posedge clk_i) begin
    // Program can only clear bits; a cleared bit needs an erase to return
    if (wr_prog) begin
      mem[st.addr] <= mem[st.addr] & st.data;
    end
    // Erase writes the whole page in the commit cycle
    for (int i = 0; i < (1 << PAGE_W); i++) begin
      if (wr_erase) begin
        mem[page_base | `FLASH_ADDR_W'(i)] <= `ERASED_BYTE;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All outputs come straight from registered state
  // Stall holds the core for the whole timed operation
  assign lnk.stall = st.busy;
  assign lnk.done = st.done;
  assign lnk.flash_err_rst = st.ferr;
  assign lnk.select = st.sel;
  assign lnk.key_state = st.ks;
  assign rd_data_o = st.rdat;
  // Status pins for the rest of the chip
  assign disabled_o = (st.ks == flash_lock_pkg::KS_DISABLED);
  assign busy_o = st.busy;
endmodule

/* File: logic/flash_lock_core.sv */
// Processor-side end: Wishbone command registers drive link requests
`timescale 1ns/1ns
`include "flash_lock_defines.svh"
module flash_lock_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt
  output logic irq_o,
  // Link to device
  flash_lock_if.core lnk
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic req;
    flash_lock_pkg::op_e op;
    logic [13:0] addr;
    logic [7:0] data;
    logic pend;                      // Request awaiting done
    logic sup_on;
    logic sup_rst;
    logic [2:0] irq;                 // Sticky events
    logic [2:0] mask;
  } state_s;
  state_s st, next_st;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic acc;
    logic [2:0] ev;
    acc = cyc_i & stb_i & ~st.ack;
    ev = '0;
    ev[`EV_DONE] = lnk.done;
    ev[`EV_VIOL] = (lnk.key_state == flash_lock_pkg::KS_DISABLED);
    ev[`EV_FERR] = lnk.flash_err_rst;
    next_st = st;
    next_st.ack = acc;
    next_st.req = 1'b0;
    if (lnk.done || lnk.flash_err_rst) begin
      next_st.pend = 1'b0;
    end
    next_st.rdat = '0;
    if (acc && we_i && sel_i[0]) begin
      case (adr_i)
        // Command: op[9:8], data[7:0], addr[23:10], supply bits [25:24]
        `WB_CTRL: begin
          next_st.sup_on = dat_i[24];
          next_st.sup_rst = dat_i[25];
          if (!st.pend && sel_i[3]) begin
            next_st.req = 1'b1;
            next_st.pend = 1'b1;
            next_st.op = flash_lock_pkg::op_e'(dat_i[9:8]);
            next_st.data = dat_i[7:0];
            next_st.addr = dat_i[23:10];
          end
        end
        `WB_IRQ: next_st.irq = st.irq & ~dat_i[2:0];
        `WB_MASK: next_st.mask = dat_i[2:0];
        default: ;
      endcase
    end else if (acc) begin
      case (adr_i)
        `WB_CTRL: next_st.rdat = {6'h00, st.sup_rst, st.sup_on, st.addr,
                                  st.op, st.data};
        `WB_STAT: next_st.rdat = {24'h0000_00, lnk.key_state, 1'b0,
                                  st.pend, lnk.stall, lnk.select};
        `WB_IRQ: next_st.rdat = {29'h0000_0000, st.irq};
        `WB_MASK: next_st.rdat = {29'h0000_0000, st.mask};
        default: next_st.rdat = '0;
      endcase
    end
    // Set wins over clear
    next_st.irq = next_st.irq | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ack_o = st.ack;
  assign dat_o = st.rdat;
  assign irq_o = |(st.irq & st.mask);
  assign lnk.req = st.req;
  assign lnk.op = st.op;
  assign lnk.addr = st.addr;
  assign lnk.data = st.data;
  assign lnk.supply_on = st.sup_on;
  assign lnk.supply_rst_en = st.sup_rst;
endmodule

/* File: verification/flash_lock_props.sv */
// Link assertions for the flash lock pair
`timescale 1ns/1ns
module flash_lock_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic req,
  input wire flash_lock_pkg::op_e op,
  input wire logic [7:0] data,
  input wire logic stall,
  input wire logic done,
  input wire logic flash_err_rst,
  input wire logic supply_on,
  input wire logic supply_rst_en,
  input wire logic select,
  input wire logic [3:0] key_state
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Key write taken by the device
  wire key = req && op == flash_lock_pkg::OP_KEY && !stall;
  // Program or erase with select set
  wire fop = req && op[1] != op[0] && select && !stall;
  // Monitor armed as reset source
  wire arm = supply_on && supply_rst_en;
  property p_first;
    key && key_state == 4'h1 && data == 8'hA5 |=> key_state == 4'h2;
  endproperty
  a_first: assert property (p_first) else $error("first key lost");
  property p_second;
    key && key_state == 4'h2 && data == 8'hF1 |=> key_state == 4'h4;
  endproperty
  a_second: assert property (p_second) else $error("no unlock");
  property p_bad;
    key && key_state == 4'h2 && data != 8'hF1 |=> key_state == 4'h8;
  endproperty
  a_bad: assert property (p_bad) else $error("bad key kept");
  property p_early;
    fop && arm && key_state[1:0] != 2'b00 |=> key_state == 4'h8;
  endproperty
  a_early: assert property (p_early) else $error("early op kept");
  property p_sticky;
    key_state == 4'h8 && !flash_err_rst |=> key_state == 4'h8;
  endproperty
  a_sticky: assert property (p_sticky) else $error("left disabled");
  property p_ferr;
    fop && !arm && key_state != 4'h8 |-> ##[1:2] flash_err_rst;
  endproperty
  a_ferr: assert property (p_ferr) else $error("no error reset");
  property p_stall;
    fop && arm && key_state == 4'h4 |=> stall ##[1:12] (done && !stall);
  endproperty
  a_stall: assert property (p_stall) else $error("stall wrong");
  property p_relock;
    done && $past(stall) |-> ##[0:1] key_state == 4'h1;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  property p_hold;
    select && !(req && op == flash_lock_pkg::OP_SEL) && !flash_err_rst |=> select;
  endproperty
  a_hold: assert property (p_hold) else $error("select lost");
endmodule

/* File: verification/test_flash_write_lock_key.sv */
// Bench driving both ends of the flash lock pair
`timescale 1ns/1ns
module test_flash_write_lock_key;
  // Bus master, flash read port, counters
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, dis, v, busy;
  logic [3:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, dat;
  logic [13:0] ra = 0;
  logic [7:0] rd;
  int errors = 0, num_checks = 0, cycles = 0, ferrs = 0, busy_cycles = 0;
  // Short operation times for the bench
  localparam int PROG_N = 4;
  localparam int ERASE_N = 8;
  flash_lock_if lnk();
  flash_lock_device #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) i_flash_lock_device (
    .clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .rd_addr_i(ra), .rd_data_o(rd),
    .disabled_o(dis), .busy_o(busy));
  flash_lock_core i_flash_lock_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat),
    .ack_o(ack), .irq_o(irq), .lnk(lnk));
  flash_lock_props i_props (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req), .op(lnk.op),
    .data(lnk.data), .stall(lnk.stall), .done(lnk.done), .select(lnk.select),
    .flash_err_rst(lnk.flash_err_rst), .supply_on(lnk.supply_on),
    .supply_rst_en(lnk.supply_rst_en), .key_state(lnk.key_state));
  // Clock, hang limit, error pulse count
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (lnk.flash_err_rst === 1'b1) ferrs <= ferrs + 1;
    if (busy === 1'b1) busy_cycles <= busy_cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  // One classic cycle, held until ack
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Command, then poll until nothing pending
  task automatic cmd(input logic [1:0] o, input logic [13:0] a, input logic [7:0] d,
                     input logic arm);
    wb(4'h0, 1, {6'h00, arm, arm, a, o, d});
    do wb(4'h4, 0, 0); while (rdat[2:1] !== 2'b00);
  endtask
  task automatic stat(input logic [7:0] e);
    wb(4'h4, 0, 0);
    chk(rdat & 32'h0000_00F1, {24'h00_0000, e});
  endtask
  task automatic rdf(input logic [13:0] a, input logic [7:0] e);
    @(posedge clk_i) ra <= a;
    repeat (2) @(posedge clk_i);
    chk({24'h00_0000, rd}, {24'h00_0000, e});
  endtask
  task automatic unlock;
    cmd(0, 0, 8'hA5, 1);
    cmd(0, 0, 8'hF1, 1);
  endtask
  task automatic do_reset;
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
  endtask
  // Erase, program twice, long gap between keys
  task automatic t_prog;
    stat(8'h10);
    cmd(3, 0, 8'h01, 1);
    cmd(0, 0, 8'hA5, 1);
    repeat (300) @(posedge clk_i);
    cmd(0, 0, 8'hF1, 1);
    stat(8'h41);
    cmd(2, 14'h0205, 0, 1);
    chk(busy_cycles, ERASE_N);
    stat(8'h11);
    rdf(14'h0205, 8'hFF);
    unlock();
    cmd(1, 14'h0205, 8'h5A, 1);
    rdf(14'h0205, 8'h5A);
    unlock();
    cmd(1, 14'h0205, 8'hF0, 1);
    rdf(14'h0205, 8'h50);
    cmd(3, 0, 8'h00, 1);
    stat(8'h10);
    cmd(1, 14'h0205, 8'h00, 1);
    stat(8'h10);
    rdf(14'h0205, 8'h50);
    chk(busy_cycles, ERASE_N + 2 * PROG_N);
    $display("prog test ends");
  endtask
  // Wrong second key, then early operation
  task automatic t_lock;
    do_reset();
    cmd(3, 0, 8'h01, 1);
    cmd(0, 0, 8'hA5, 1);
    cmd(0, 0, 8'h3C, 1);
    stat(8'h81);
    unlock();
    cmd(1, 14'h0205, 0, 1);
    rdf(14'h0205, 8'h50);
    chk(dis, 1);
    do_reset();
    stat(8'h10);
    cmd(3, 0, 8'h01, 1);
    cmd(1, 14'h0205, 0, 1);
    stat(8'h81);
    rdf(14'h0205, 8'h50);
    $display("lock test ends");
  endtask
  // Unarmed monitor, then mask and clear
  task automatic t_ferr;
    do_reset();
    cmd(3, 0, 8'h01, 1);
    unlock();
    cmd(1, 14'h0205, 0, 0);
    chk(ferrs, 1);
    wb(4'h0, 0, 0);
    chk(rdat, {6'h00, 2'b00, 14'h0205, 2'b01, 8'h00});
    rdf(14'h0205, 8'h50);
    wb(4'h8, 0, 0);
    chk(rdat[2], 1);
    wb(4'hC, 1, 7);
    wb(4'hC, 0, 0);
    chk(rdat, 7);
    @(posedge clk_i) v = irq;
    chk(v, 1);
    wb(4'hC, 1, 0);
    @(posedge clk_i);
    chk(irq, 0);
    wb(4'hC, 1, 7);
    wb(4'h8, 1, 7);
    @(posedge clk_i);
    chk(irq, 0);
    $display("error test ends");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_prog();
    t_lock();
    t_ferr();
    conclude();
  end
endmodule
